// *** logic/ptab_consts.vh ***
`ifndef PTAB_CONSTS_VH
`define PTAB_CONSTS_VH

// register offsets on the internal i/o bus
`define PTAB_OFS_TA_ENABLE      8'ha0
`define PTAB_OFS_TA_CONST_PRE   8'ha3
`define PTAB_OFS_TA_SRC_PRIO    8'ha4
`define PTAB_OFS_TA_CONST_BAUD0 8'ha9
`define PTAB_OFS_TA_CONST_BAUD1 8'hab
`define PTAB_OFS_TA_CONST_BAUD2 8'had
`define PTAB_OFS_TA_CONST_BAUD3 8'haf
`define PTAB_OFS_TB_EN_STATUS   8'hb0
`define PTAB_OFS_TB_SRC_PRIO    8'hb1
`define PTAB_OFS_M1_UPPER       8'hb2
`define PTAB_OFS_M1_LOW         8'hb3
`define PTAB_OFS_M2_UPPER       8'hb4
`define PTAB_OFS_M2_LOW         8'hb5
`define PTAB_OFS_CNT_UPPER      8'hbe
`define PTAB_OFS_CNT_LOW        8'hbf

// field positions
`define PTAB_BIT_CLK_EN         0
`define PTAB_BIT_MATCH1         1
`define PTAB_BIT_MATCH2         2
`define PTAB_BIT_BAUD_SRC_LO    4
`define PTAB_BIT_UPPER_LSB      6

// timer b counter source codes (bits 3:2)
`define PTAB_TB_SRC_PRESCALE    2'h0
`define PTAB_TB_SRC_DIV2        2'h1

// reset values
`define PTAB_RST_CTRL           8'h00
`define PTAB_RST_SUBTIMER       8'hff
`define PTAB_RST_MATCH          10'h3ff

// pclk/2 divided by eight for the slow timer b source
`define PTAB_SLOW_DIV_LAST      3'h7

`endif

// *** logic/ptab_subtimer.v ***
`default_nettype none

module ptab_subtimer (
    // clock and reset
    input  wire       sys_clk,
    input  wire       rst_b,
    // reload write
    input  wire       wr_reload,
    input  wire [7:0] wdata,
    // count input and output pulse
    input  wire       tick_in,
    output reg        pulse_out
);
`include "ptab_consts.vh"

    reg [7:0] reload_r;
    reg [7:0] count_r;

    // write-only reload, taken on the next reload only
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            reload_r <= `PTAB_RST_SUBTIMER;
        end else if (wr_reload) begin
            reload_r <= wdata;
        end
    end

    // arbitrary start: counter is not cleared to zero
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            count_r   <= `PTAB_RST_SUBTIMER;
            pulse_out <= 1'b0;
        end else begin
            pulse_out <= 1'b0;
            if (tick_in) begin
                if (count_r == 8'h00) begin
                    count_r   <= reload_r;
                    pulse_out <= 1'b1;
                end else begin
                    count_r <= count_r - 8'h01;
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** logic/ptab_match_chan.v ***
`default_nettype none

module ptab_match_chan (
    // clock and reset
    input  wire       sys_clk,
    input  wire       rst_b,
    // register writes
    input  wire       wr_upper,
    input  wire       wr_low,
    input  wire [7:0] wdata,
    // counter
    input  wire       cnt_tick,
    input  wire [9:0] cnt_nxt,
    // match event
    output reg        match_pulse,
    output wire       valid
);
`include "ptab_consts.vh"

    reg [1:0] hold_hi_r;
    reg [7:0] hold_lo_r;
    reg       hold_full_r;
    reg [9:0] match_r;
    reg       valid_r;

    wire hit      = valid_r && (cnt_nxt == match_r);
    wire valid_kp = valid_r && !hit;
    wire load     = cnt_tick && !valid_kp && hold_full_r;

    assign valid = valid_r;

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            hold_hi_r   <= 2'h0;
            hold_lo_r   <= 8'h00;
            hold_full_r <= 1'b0;
            match_r     <= `PTAB_RST_MATCH;
            valid_r     <= 1'b0;
            match_pulse <= 1'b0;
        end else begin
            match_pulse <= cnt_tick && hit;
            if (wr_upper) begin
                hold_hi_r <= wdata[7:6];
            end
            if (wr_low) begin
                hold_lo_r <= wdata;
            end
            // a low-byte write in the transfer cycle stays pending
            hold_full_r <= wr_low || (hold_full_r && !load);
            if (cnt_tick) begin
                if (load) begin
                    match_r <= {hold_hi_r, hold_lo_r};
                    valid_r <= 1'b1;
                end else begin
                    valid_r <= valid_kp;
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** logic/ptab_timers.v ***
// Function
// - upper four timer a control bits pick baud subtimer clock: pclk/2 or prescaler.
// - low two timer a control bits: 00 interrupt off, else priority 1-3.
// - each subtimer has a write-only 8-bit reload register, values 0 to 255.
// - after reset timer a clock enable is clear, all subtimers stopped.
// - reload may change while running; takes effect at next reload.
// - subtimer counters are not cleared, first pulse may come any time.
// - timer b main clock is pclk/2, gated by its enable bit 0.
// - timer b counter uses pclk/2, pclk/16 or prescaler; code 00 prescaler.
// - timer b priority bits: 00 interrupt off, else priority equals value.
// - timer b has a free-running 10-bit counter and two match registers.
// - counter becoming equal to a match value gives a one-clock pulse.
// - match starts invalid; written value loads on next timer b tick, valid.
// - while valid writes wait; a match invalidates and loads the held value.
// - status bits 2 and 1 flag matches, cleared on read, written as enables.
// - bits 7:6 of upper match register hold match bits 9:8.
// - subtimer divides by reload plus one, pulsing when it reloads.
// - timer a enable bit 0 gates pclk/2 into all subtimers.
`default_nettype none

module ptab_timers (
    // clock and reset
    input  wire       sys_clk,
    input  wire       rst_b,
    // internal i/o bus
    input  wire [7:0] io_addr,
    input  wire       io_wr,
    input  wire       io_rd,
    input  wire [7:0] io_wdata,
    output reg  [7:0] io_rdata,
    // timer a outputs
    output wire       prescale_pulse,
    output wire [3:0] baud_pulse,
    output wire [1:0] timer_a_irq_priority,
    // timer b outputs
    output wire [1:0] match_pulse,
    output wire       timer_b_irq_req,
    output wire [1:0] timer_b_irq_priority
);
`include "ptab_consts.vh"

    // address match for write and read strobes
    function hit_wr;
        input [7:0] ofs;
        begin
            hit_wr = io_wr && (io_addr == ofs);
        end
    endfunction

    function hit_rd;
        input [7:0] ofs;
        begin
            hit_rd = io_rd && (io_addr == ofs);
        end
    endfunction

    // ---------------------------------------------------------------
    // control registers
    reg       ta_en_r;
    reg [7:0] ta_ctrl_r;
    reg       tb_en_r;
    reg [1:0] tb_ien_r;
    reg [1:0] tb_status_r;
    reg [3:0] tb_ctrl_r;

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            ta_en_r   <= 1'b0;
            ta_ctrl_r <= `PTAB_RST_CTRL;
            tb_en_r   <= 1'b0;
            tb_ien_r  <= 2'h0;
            tb_ctrl_r <= 4'h0;
        end else begin
            if (hit_wr(`PTAB_OFS_TA_ENABLE)) begin
                ta_en_r <= io_wdata[`PTAB_BIT_CLK_EN];
            end
            if (hit_wr(`PTAB_OFS_TA_SRC_PRIO)) begin
                ta_ctrl_r <= io_wdata;
            end
            if (hit_wr(`PTAB_OFS_TB_EN_STATUS)) begin
                tb_en_r  <= io_wdata[`PTAB_BIT_CLK_EN];
                tb_ien_r <= io_wdata[`PTAB_BIT_MATCH2:`PTAB_BIT_MATCH1];
            end
            if (hit_wr(`PTAB_OFS_TB_SRC_PRIO)) begin
                tb_ctrl_r <= io_wdata[3:0];
            end
        end
    end

    assign timer_a_irq_priority = ta_ctrl_r[1:0];
    assign timer_b_irq_priority = tb_ctrl_r[1:0];

    // ---------------------------------------------------------------
    // pclk/2 base tick, one sys_clk in two
    reg half_r;

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            half_r <= 1'b0;
        end else begin
            half_r <= ~half_r;
        end
    end

    wire tick_a = half_r && ta_en_r;
    wire tick_b = half_r && tb_en_r;

    // ---------------------------------------------------------------
    // timer a: prescaler plus four baud subtimers
    wire [7:0] const_ofs [0:3];
    assign const_ofs[0] = `PTAB_OFS_TA_CONST_BAUD0;
    assign const_ofs[1] = `PTAB_OFS_TA_CONST_BAUD1;
    assign const_ofs[2] = `PTAB_OFS_TA_CONST_BAUD2;
    assign const_ofs[3] = `PTAB_OFS_TA_CONST_BAUD3;

    ptab_subtimer u_prescale (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .wr_reload (hit_wr(`PTAB_OFS_TA_CONST_PRE)),
        .wdata     (io_wdata),
        .tick_in   (tick_a),
        .pulse_out (prescale_pulse)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_baud
            // source bit 1 takes the prescaler, 0 takes gated pclk/2
            wire sel_pre = ta_ctrl_r[`PTAB_BIT_BAUD_SRC_LO + gi];
            wire tick_in = sel_pre ? prescale_pulse : tick_a;

            ptab_subtimer u_baud (
                .sys_clk   (sys_clk),
                .rst_b     (rst_b),
                .wr_reload (hit_wr(const_ofs[gi])),
                .wdata     (io_wdata),
                .tick_in   (tick_in),
                .pulse_out (baud_pulse[gi])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // timer b: count source selection
    reg [2:0] slow_div_r;
    reg       slow_tick;

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            slow_div_r <= 3'h0;
        end else if (tick_b) begin
            slow_div_r <= slow_div_r + 3'h1;
        end
    end

    always @* begin
        slow_tick = tick_b && (slow_div_r == `PTAB_SLOW_DIV_LAST);
    end

    reg cnt_tick;

    // prescaler is already gated by the timer a enable
    always @* begin
        case (tb_ctrl_r[3:2])
            `PTAB_TB_SRC_PRESCALE: cnt_tick = tb_en_r && prescale_pulse;
            `PTAB_TB_SRC_DIV2:     cnt_tick = tick_b;
            default:               cnt_tick = slow_tick;
        endcase
    end

    // ---------------------------------------------------------------
    // free-running 10-bit counter
    reg  [9:0] count_r;
    wire [9:0] count_nxt = count_r + 10'h001;

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            count_r <= 10'h000;
        end else if (cnt_tick) begin
            count_r <= count_nxt;
        end
    end

    // ---------------------------------------------------------------
    // two match channels
    ptab_match_chan u_match1 (
        .sys_clk     (sys_clk),
        .rst_b       (rst_b),
        .wr_upper    (hit_wr(`PTAB_OFS_M1_UPPER)),
        .wr_low      (hit_wr(`PTAB_OFS_M1_LOW)),
        .wdata       (io_wdata),
        .cnt_tick    (cnt_tick),
        .cnt_nxt     (count_nxt),
        .match_pulse (match_pulse[0]),
        .valid       ()
    );

    ptab_match_chan u_match2 (
        .sys_clk     (sys_clk),
        .rst_b       (rst_b),
        .wr_upper    (hit_wr(`PTAB_OFS_M2_UPPER)),
        .wr_low      (hit_wr(`PTAB_OFS_M2_LOW)),
        .wdata       (io_wdata),
        .cnt_tick    (cnt_tick),
        .cnt_nxt     (count_nxt),
        .match_pulse (match_pulse[1]),
        .valid       ()
    );

    // ---------------------------------------------------------------
    // match status: read clears, a match in the same cycle wins
    wire rd_status = hit_rd(`PTAB_OFS_TB_EN_STATUS);

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            tb_status_r <= 2'h0;
        end else begin
            tb_status_r <= match_pulse | (tb_status_r & {2{~rd_status}});
        end
    end

    assign timer_b_irq_req = (|(tb_status_r & tb_ien_r)) && (tb_ctrl_r[1:0] != 2'h0);

    // ---------------------------------------------------------------
    // read data, registered; write-only and unmapped read as zero
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            io_rdata <= 8'h00;
        end else if (io_rd) begin
            case (io_addr)
                `PTAB_OFS_TB_EN_STATUS: io_rdata <= {5'h00, tb_status_r, tb_en_r};
                `PTAB_OFS_CNT_UPPER:    io_rdata <= {count_r[9:8], 6'h00};
                `PTAB_OFS_CNT_LOW:      io_rdata <= count_r[7:0];
                default:                io_rdata <= 8'h00;
            endcase
        end
    end

endmodule

`default_nettype wire

// *** test/ptab_timers_assertions.sv ***
`default_nettype none
module ptab_timers_chk (
    // clock, reset, bus
    input wire logic       sys_clk,
    input wire logic       rst_b,
    input wire logic [7:0] io_addr,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    // timer outputs
    input wire logic       prescale_pulse,
    input wire logic [3:0] baud_pulse,
    input wire logic [1:0] timer_a_irq_priority,
    input wire logic [1:0] match_pulse,
    input wire logic       timer_b_irq_req,
    input wire logic [1:0] timer_b_irq_priority
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ta_en_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // shadow of the timer a clock enable
    always @(posedge sys_clk) begin
        if (!rst_b)
            ta_en_r <= 1'b0;
        else if (io_wr && io_addr == 8'ha0)
            ta_en_r <= io_wdata[0];
    end
    property p_pa;
        io_wr && io_addr == 8'ha4 |=> timer_a_irq_priority == 2'($past(io_wdata));
    endproperty
    a_pa: assert property (p_pa) else $error("timer a priority");
    property p_pb;
        io_wr && io_addr == 8'hb1 |=> timer_b_irq_priority == 2'($past(io_wdata));
    endproperty
    a_pb: assert property (p_pb) else $error("timer b priority");
    property p_off;
        timer_b_irq_priority == 2'h0 |-> !timer_b_irq_req;
    endproperty
    a_off: assert property (p_off) else $error("irq while off");
    property p_wo;
        io_rd && io_addr inside {8'ha3, 8'ha9, 8'hab, 8'had, 8'haf} |=> io_rdata == 8'h00;
    endproperty
    a_wo: assert property (p_wo) else $error("reload readable");
    property p_cu;
        io_rd && io_addr == 8'hbe |=> io_rdata[5:0] == 6'h00;
    endproperty
    a_cu: assert property (p_cu) else $error("counter upper");
    property p_stop;
        !ta_en_r [*4] |-> !prescale_pulse && baud_pulse == 4'h0;
    endproperty
    a_stop: assert property (p_stop) else $error("timer a runs");
    property p_mp;
        match_pulse != 2'h0 |=> (match_pulse & $past(match_pulse)) == 2'h0;
    endproperty
    a_mp: assert property (p_mp) else $error("long match pulse");
    sequence s_st_rd;
        io_rd && io_addr == 8'hb0 && match_pulse == 2'h0;
    endsequence
    property p_clr;
        s_st_rd ##1 match_pulse == 2'h0 ##1 s_st_rd |=> io_rdata[2:1] == 2'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("status kept");
    c_m1: cover property (match_pulse[0]);
    c_m2: cover property (match_pulse[1]);
    c_irq: cover property (timer_b_irq_req);
endmodule
bind ptab_timers ptab_timers_chk u_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .prescale_pulse(prescale_pulse), .baud_pulse(baud_pulse),
    .timer_a_irq_priority(timer_a_irq_priority), .match_pulse(match_pulse),
    .timer_b_irq_req(timer_b_irq_req), .timer_b_irq_priority(timer_b_irq_priority)
);
`default_nettype wire

// *** test/ptab_timers_tb.sv ***
`default_nettype none
module ptab_timers_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  io_addr = 8'h00;
    logic        io_wr = 1'b0;
    logic        io_rd = 1'b0;
    logic [7:0]  io_wdata = 8'h00;
    logic [7:0]  io_rdata;
    logic        prescale_pulse;
    logic [3:0]  baud_pulse;
    logic [1:0]  ta_prio;
    logic [1:0]  match_pulse;
    logic        irq_req;
    logic [1:0]  tb_prio;
    logic [6:0]  pv;
    logic        rd_d = 1'b0;
    logic [7:0]  exp_q[$];
    logic [7:0]  msk_q[$];
    logic [31:0] lfsr = 32'hdd8f;
    logic [7:0]  v;
    logic [7:0]  ro_a[16] = '{8'ha0, 8'ha3, 8'ha4, 8'ha9, 8'hab, 8'had, 8'haf, 8'hb0,
                              8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hbe, 8'hbf, 8'h10};
    logic [1:0]  src[3] = '{2'h1, 2'h2, 2'h0};
    int          mul[3] = '{2, 16, 4};
    int          n_errors = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          p;
    int          n;
    assign pv = {match_pulse, baud_pulse, prescale_pulse};
    always #2.5 sys_clk = ~sys_clk;
    ptab_timers u_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .prescale_pulse(prescale_pulse), .baud_pulse(baud_pulse),
        .timer_a_irq_priority(ta_prio), .match_pulse(match_pulse),
        .timer_b_irq_req(irq_req), .timer_b_irq_priority(tb_prio)
    );
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // one bus access, then one idle cycle
    task automatic op(input logic r, input logic [7:0] a, input logic [7:0] d);
        io_rd <= r;
        io_wr <= !r;
        io_addr <= a;
        io_wdata <= d;
        @(posedge sys_clk);
        io_rd <= 1'b0;
        io_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        op(1'b1, a, 8'h00);
    endtask
    // sync to a pulse of pv[k], then cycles to the next one
    task automatic per(input int k, output int q);
        int c;
        repeat (2) begin
            c = 0;
            do begin
                @(negedge sys_clk);
                c++;
            end while (pv[k] !== 1'b1 && c < 20000);
        end
        q = c;
        @(posedge sys_clk);
    endtask
    task automatic cnt(input int len, input logic [6:0] m, output int q);
        q = 0;
        repeat (len) begin
            @(negedge sys_clk);
            if ((pv & m) !== 7'h0)
                q++;
        end
        @(posedge sys_clk);
    endtask
    always @(negedge sys_clk) begin
        if (rd_d)
            check({8'h0, io_rdata & msk_q.pop_front()}, {8'h0, exp_q.pop_front()});
        rd_d <= io_rd;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 100000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        foreach (ro_a[i]) rd(ro_a[i], 8'h00, 8'hff);
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            op(1'b0, 8'ha4, {lfsr[7:2], 2'(i)});
            op(1'b0, 8'hb1, {lfsr[15:12], 2'h1, 2'(i)});
            check({14'h0, ta_prio}, 16'(i));
            check({14'h0, tb_prio}, 16'(i));
        end
        op(1'b0, 8'ha3, 8'h00);
        op(1'b0, 8'ha4, 8'h00);
        op(1'b0, 8'ha0, 8'h01);
        per(0, p);
        check(16'(p), 16'd2);
        for (int k = 0; k < 8; k++) begin
            lfsr = lfsr_next(lfsr);
            v = {5'h0, lfsr[2:0]};
            if (k == 4)
                op(1'b0, 8'ha3, 8'h01);
            op(1'b0, 8'ha4, k < 4 ? 8'h00 : 8'hf0);
            op(1'b0, 8'ha9 + 8'(2 * (k % 4)), v);
            per(k % 4 + 1, p);
            check(16'(p), 16'((v + 1) * (k < 4 ? 2 : 4)));
        end
        // phase alignment: zero both reloads, let both reload, then set alike
        op(1'b0, 8'ha9, 8'h00);
        op(1'b0, 8'hab, 8'h00);
        repeat (1100) @(posedge sys_clk);
        op(1'b0, 8'ha0, 8'h00);
        op(1'b0, 8'ha9, 8'h03);
        op(1'b0, 8'hab, 8'h03);
        op(1'b0, 8'ha0, 8'h01);
        n = 0;
        p = 0;
        repeat (200) begin
            @(negedge sys_clk);
            n += (pv[1] !== pv[2]) ? 1 : 0;
            p += (pv[1] === 1'b1) ? 1 : 0;
        end
        check(16'(n), 16'h0);
        check(16'(p > 10), 16'h1);
        // baud subtimer 3 on the prescaler with reload 255: 1024 cycles per pulse
        op(1'b0, 8'haf, 8'hff);
        per(4, p);
        check(16'(p), 16'd1024);
        op(1'b0, 8'ha0, 8'h00);
        repeat (4) @(posedge sys_clk);
        cnt(600, 7'h1f, n);
        check(16'(n), 16'h0);
        op(1'b0, 8'hb1, 8'h05);
        op(1'b0, 8'hb0, 8'h07);
        for (int c = 0; c < 2; c++) begin
            lfsr = lfsr_next(lfsr);
            op(1'b0, 8'hb2 + 8'(2 * c), {2'h1, lfsr[5:0]});
            op(1'b0, 8'hb3 + 8'(2 * c), 8'h40 + 8'(c * 64));
            n = 0;
            while (match_pulse[c] !== 1'b1 && n < 5000) begin
                @(negedge sys_clk);
                n++;
            end
            @(posedge sys_clk);
            rd(8'hbe, 8'h40, 8'hff);
            rd(8'hbf, 8'h40 + 8'(c * 64), 8'hfc);
            check({15'h0, irq_req}, 16'h1);
            rd(8'hb0, 8'h01 | (8'h02 << c), 8'hff);
            rd(8'hb0, 8'h01, 8'hff);
            check({15'h0, irq_req}, 16'h0);
        end
        cnt(2100, 7'h60, n);
        check(16'(n), 16'h0);
        op(1'b0, 8'ha0, 8'h01);
        for (int s = 0; s < 3; s++) begin
            op(1'b0, 8'hb1, {4'h0, src[s], 2'h1});
            op(1'b0, 8'hb3, 8'h60);
            // let one counter tick move the first value into the match register
            repeat (mul[s]) @(posedge sys_clk);
            op(1'b0, 8'hb3, 8'h80);
            per(5, p);
            check(16'(p), 16'(32 * mul[s]));
        end
        print_verdict();
    end
endmodule
`default_nettype wire
